// File: uic_pkg.sv
package uic_pkg;
   // register location on the internal register port
   localparam logic [7:0] UIC_IFCFG_OFS = 8'h14;
   localparam logic [7:0] UIC_FILTCFG_OFS = 8'h15;
   // field positions of interface_config
   localparam int UIC_TOPO_HI = 15;
   localparam int UIC_TOPO_LO = 14;
   localparam int UIC_UP_FLOAT = 13;
   localparam int UIC_LO_FLOAT = 12;
   localparam int UIC_KEEPALIVE = 9;
   localparam int UIC_HOST = 8;
   localparam int UIC_CHK_BYTE = 3;
   localparam int UIC_CRC_DIS = 2;
   localparam int UIC_ALARM_EN = 1;
   localparam int UIC_DBL_BUF = 0;
   // reset value, writable bits, bits kept over a software power-on reset
   localparam logic [15:0] UIC_IFCFG_RST = 16'hC108;
   localparam logic [15:0] UIC_IFCFG_WMASK = 16'hFEFF;
   localparam logic [15:0] UIC_IFCFG_KEEP = 16'hF102;
   localparam logic [15:0] UIC_ZERO16 = 16'h0000;
   // topology codes
   typedef enum logic [1:0]
   {
      UIC_TOPO_EXT_LOOP = 2'b00,
      UIC_TOPO_INT_LOOP = 2'b01,
      UIC_TOPO_DIFF_ALARM = 2'b10,
      UIC_TOPO_DUAL = 2'b11
   } uic_topo_t;
   // idle detection on a relayed path
   localparam int UIC_CLK_NS = 25;
   localparam int UIC_IDLE_NS = 1000;
   localparam logic [5:0] UIC_IDLE_CYC = 6'((UIC_IDLE_NS + UIC_CLK_NS - 1) / UIC_CLK_NS);
   localparam logic [5:0] UIC_CNT_ZERO = 6'h00;
   localparam logic [5:0] UIC_CNT_ONE = 6'h01;
   localparam int UIC_SYNC_W = 3;
endpackage

// File: uic_sync.sv
`timescale 1ns/10ps
module uic_sync
   import uic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [UIC_SYNC_W-1:0] async_in,
   output logic [UIC_SYNC_W-1:0] sync_out
);
   logic [UIC_SYNC_W-1:0] meta_q;

   // two flip-flop level synchroniser
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: uic_interface_config.sv
`timescale 1ns/10ps
// Notes on behaviour
// - topology selector decodes four path arrangements
// - upward path relays lower receive to upper transmit
// - dual path: writes only from host path
// - downward path relays upper receive to lower transmit
// - software reset keeps topology, idles, host, alarm
// - power-up topology is dual path
// - upper transmitter idles low or floats
// - lower transmitter idles low or floats
// - spare bits read back last written value until a software reset clears them
// - keepalive enable appends alive counter byte
// - host indicator read-only, one means upward
// - host changes only on select commands
// - check byte required when bit set
// - crc disable skips packet check enforcement
// - alarm disabled single-ended: output floats, input ignored
// - alarm disabled differential: down path idles
// - alarm enabled: local and neighbour alarms forwarded
// - double buffer moves results at next start
module uic_interface_config
   import uic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [15:0] reg_wr_data,
   input wire logic reg_wr_from_up,
   input wire logic [7:0] reg_rd_addr,
   output logic [15:0] reg_rd_data,
   output logic reg_wr_refused,
   input wire logic select_up_host_cmd,
   input wire logic select_down_host_cmd,
   input wire logic software_power_on_reset,
   input wire logic [15:0] primary_alarm_status,
   input wire logic acq_start,
   input wire logic acq_end,
   output logic result_transfer,
   input wire logic lower_receive_port,
   input wire logic upper_receive_port,
   input wire logic alarm_input_pin,
   output logic upper_transmit_port_o,
   output logic upper_transmit_port_oe,
   output logic lower_transmit_port_o,
   output logic lower_transmit_port_oe,
   output logic alarm_output_pin_o,
   output logic alarm_output_pin_oe,
   output logic [1:0] serial_topology_sel,
   output logic host_path_indicator,
   output logic keepalive_count_enable,
   output logic check_byte_required,
   output logic crc_disable,
   output logic alarm_enable,
   output logic double_buffer_enable
);
   typedef struct packed
   {
      logic [15:0] cfg;
      logic [15:0] rd_data;
      logic wr_refused;
      logic xfer;
      logic xfer_pend;
      logic [5:0] up_cnt;
      logic [5:0] lo_cnt;
      logic tx_up;
      logic tx_up_oe;
      logic tx_lo;
      logic tx_lo_oe;
      logic alm;
      logic alm_oe;
   } uic_state_t;

   uic_state_t s_q;
   uic_state_t s_d;
   logic [UIC_SYNC_W-1:0] pins_s;
   logic rx_lo_s;
   logic rx_up_s;
   logic alm_in_s;
   logic wr_hit;
   logic wr_ok;
   logic local_alarm;
   logic alarm_level;
   uic_topo_t topo;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   uic_sync u_sync
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({alarm_input_pin, upper_receive_port, lower_receive_port}),
      .sync_out(pins_s)
   );

   assign rx_lo_s = pins_s[0];
   assign rx_up_s = pins_s[1];
   assign alm_in_s = pins_s[2];

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_dual(input logic [15:0] c);
      is_dual = (c[UIC_TOPO_HI:UIC_TOPO_LO] == UIC_TOPO_DUAL);
   endfunction

   function automatic logic [5:0] idle_count(input logic active, input logic [5:0] cnt);
      if (active)
      begin
         idle_count = UIC_IDLE_CYC;
      end
      else if (cnt != UIC_CNT_ZERO)
      begin
         idle_count = cnt - UIC_CNT_ONE;
      end
      else
      begin
         idle_count = UIC_CNT_ZERO;
      end
   endfunction

   assign topo = uic_topo_t'(s_q.cfg[UIC_TOPO_HI:UIC_TOPO_LO]);
   assign wr_hit = reg_wr_en && (reg_wr_addr == UIC_IFCFG_OFS);
   // only the host path may write in dual topology
   assign wr_ok = !is_dual(s_q.cfg) || (reg_wr_from_up == s_q.cfg[UIC_HOST]);
   assign local_alarm = |primary_alarm_status;
   // in differential mode the neighbour alarm arrives on the down path
   assign alarm_level = local_alarm || ((topo == UIC_TOPO_DIFF_ALARM) ? rx_up_s : alm_in_s);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      s_d = s_q;
      s_d.wr_refused = 1'b0;
      s_d.xfer = 1'b0;
      // configuration register
      if (software_power_on_reset)
      begin
         s_d.cfg = (s_q.cfg & UIC_IFCFG_KEEP) | (UIC_IFCFG_RST & ~UIC_IFCFG_KEEP);
      end
      else if (wr_hit && wr_ok)
      begin
         s_d.cfg = (s_q.cfg & ~UIC_IFCFG_WMASK) | (reg_wr_data & UIC_IFCFG_WMASK);
      end
      else if (wr_hit)
      begin
         s_d.wr_refused = 1'b1;
      end
      // host selection by command only
      if (select_up_host_cmd)
      begin
         s_d.cfg[UIC_HOST] = 1'b1;
      end
      else if (select_down_host_cmd && is_dual(s_q.cfg))
      begin
         s_d.cfg[UIC_HOST] = 1'b0;
      end
      // read-back, host indicator shows live selection
      s_d.rd_data = (reg_rd_addr == UIC_IFCFG_OFS) ? s_q.cfg : UIC_ZERO16;
      // result transfer timing
      if (s_q.cfg[UIC_DBL_BUF])
      begin
         if (acq_start && (s_q.xfer_pend || acq_end))
         begin
            s_d.xfer = 1'b1;
            s_d.xfer_pend = 1'b0;
         end
         else if (acq_end)
         begin
            s_d.xfer_pend = 1'b1;
         end
      end
      else
      begin
         s_d.xfer = acq_end;
         s_d.xfer_pend = 1'b0;
      end
      // upward relay
      s_d.up_cnt = idle_count(rx_lo_s, s_q.up_cnt);
      s_d.tx_up = rx_lo_s;
      s_d.tx_up_oe = rx_lo_s || (s_q.up_cnt != UIC_CNT_ZERO) || !s_q.cfg[UIC_UP_FLOAT];
      // downward relay or differential alarm
      s_d.lo_cnt = idle_count(rx_up_s, s_q.lo_cnt);
      s_d.alm = 1'b0;
      s_d.alm_oe = 1'b0;
      case (topo)
         UIC_TOPO_DIFF_ALARM:
         begin
            if (s_q.cfg[UIC_ALARM_EN])
            begin
               s_d.tx_lo = alarm_level;
               s_d.tx_lo_oe = 1'b1;
            end
            else
            begin
               s_d.tx_lo = 1'b0;
               s_d.tx_lo_oe = !s_q.cfg[UIC_LO_FLOAT];
            end
         end
         UIC_TOPO_EXT_LOOP, UIC_TOPO_INT_LOOP, UIC_TOPO_DUAL:
         begin
            s_d.tx_lo = rx_up_s;
            s_d.tx_lo_oe = rx_up_s || (s_q.lo_cnt != UIC_CNT_ZERO) || !s_q.cfg[UIC_LO_FLOAT];
            s_d.alm = s_q.cfg[UIC_ALARM_EN] && alarm_level;
            s_d.alm_oe = s_q.cfg[UIC_ALARM_EN];
         end
         default:
         begin
            s_d.tx_lo = 1'b0;
            s_d.tx_lo_oe = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.cfg <= UIC_IFCFG_RST;
         s_q.tx_up_oe <= 1'b1;
         s_q.tx_lo_oe <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rd_data = s_q.rd_data;
   assign reg_wr_refused = s_q.wr_refused;
   assign result_transfer = s_q.xfer;
   assign upper_transmit_port_o = s_q.tx_up;
   assign upper_transmit_port_oe = s_q.tx_up_oe;
   assign lower_transmit_port_o = s_q.tx_lo;
   assign lower_transmit_port_oe = s_q.tx_lo_oe;
   assign alarm_output_pin_o = s_q.alm;
   assign alarm_output_pin_oe = s_q.alm_oe;
   assign serial_topology_sel = s_q.cfg[UIC_TOPO_HI:UIC_TOPO_LO];
   assign host_path_indicator = s_q.cfg[UIC_HOST];
   assign keepalive_count_enable = s_q.cfg[UIC_KEEPALIVE];
   assign check_byte_required = s_q.cfg[UIC_CHK_BYTE];
   assign crc_disable = s_q.cfg[UIC_CRC_DIS];
   assign alarm_enable = s_q.cfg[UIC_ALARM_EN];
   assign double_buffer_enable = s_q.cfg[UIC_DBL_BUF];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_por_keeps_topo: assert property (
      software_power_on_reset |=> serial_topology_sel == $past(serial_topology_sel)
         && alarm_enable == $past(alarm_enable))
   else $error("software reset altered kept fields");

   a_por_clears_opts: assert property (
      software_power_on_reset |=> !keepalive_count_enable && check_byte_required && !crc_disable)
   else $error("software reset did not restore options");

   a_host_read_only: assert property (
      wr_hit && !select_up_host_cmd && !select_down_host_cmd
         |=> host_path_indicator == $past(host_path_indicator))
   else $error("write changed host indicator");

   a_down_host_dual: assert property (
      $fell(host_path_indicator) |-> $past(serial_topology_sel) == UIC_TOPO_DUAL)
   else $error("down host outside dual topology");

   a_write_gate: assert property (
      wr_hit && !software_power_on_reset && is_dual(s_q.cfg) && (reg_wr_from_up != host_path_indicator)
         |=> reg_wr_refused && serial_topology_sel == $past(serial_topology_sel))
   else $error("write from non-host path accepted");

   a_spare_readback: assert property (
      wr_hit && wr_ok && !software_power_on_reset
         |=> s_q.cfg[11:10] == $past(reg_wr_data[11:10]) && s_q.cfg[7:4] == $past(reg_wr_data[7:4]))
   else $error("spare bits not stored");

   sequence s_end_buffered;
      double_buffer_enable && acq_end && !acq_start;
   endsequence

   sequence s_next_start;
      double_buffer_enable && acq_start;
   endsequence

   a_xfer_buffered: assert property (
      s_end_buffered ##1 s_next_start |=> result_transfer)
   else $error("buffered transfer missed at next start");

   a_xfer_normal: assert property (
      !double_buffer_enable && acq_end |=> result_transfer)
   else $error("transfer missed at end of acquisition");

   a_alarm_float: assert property (
      !alarm_enable && serial_topology_sel != UIC_TOPO_DIFF_ALARM |=> !alarm_output_pin_oe)
   else $error("alarm output driven while disabled");

   a_diff_idle: assert property (
      !alarm_enable && serial_topology_sel == UIC_TOPO_DIFF_ALARM && !s_q.cfg[UIC_LO_FLOAT]
         |=> lower_transmit_port_oe && !lower_transmit_port_o)
   else $error("down path not idling low");

   a_up_relay: assert property (
      rx_lo_s |=> upper_transmit_port_o && upper_transmit_port_oe)
   else $error("upward relay lost a one");

   a_up_float: assert property (
      !rx_lo_s [*2] ##0 (s_q.up_cnt == UIC_CNT_ZERO) && s_q.cfg[UIC_UP_FLOAT] |=> !upper_transmit_port_oe)
   else $error("upper transmitter not floating at idle");

   a_lo_relay: assert property (
      serial_topology_sel != UIC_TOPO_DIFF_ALARM && rx_up_s |=> lower_transmit_port_o && lower_transmit_port_oe)
   else $error("downward relay lost a one");

   a_lo_float: assert property (
      serial_topology_sel != UIC_TOPO_DIFF_ALARM && !rx_up_s && (s_q.lo_cnt == UIC_CNT_ZERO) && s_q.cfg[UIC_LO_FLOAT]
         |=> !lower_transmit_port_oe)
   else $error("lower transmitter not floating at idle");

   a_host_up_cmd: assert property (
      select_up_host_cmd |=> host_path_indicator)
   else $error("up host command not applied");

   a_por_keeps_host: assert property (
      software_power_on_reset && !select_up_host_cmd && !select_down_host_cmd
         |=> host_path_indicator == $past(host_path_indicator) && s_q.cfg[13:12] == $past(s_q.cfg[13:12]))
   else $error("software reset altered host or idle selections");

   a_alarm_pass: assert property (
      alarm_enable && serial_topology_sel != UIC_TOPO_DIFF_ALARM && (local_alarm || alm_in_s)
         |=> alarm_output_pin_o && alarm_output_pin_oe)
   else $error("alarm not passed to output");

   sequence s_quiet_gap;
      double_buffer_enable && !acq_start;
   endsequence

   a_xfer_after_gap: assert property (
      s_end_buffered ##1 s_quiet_gap ##1 s_next_start |=> result_transfer)
   else $error("buffered transfer missed after idle cycle");
endmodule

// File: uic_neighbour.sv
`timescale 1ns/10ps
module uic_neighbour
(
   input wire logic clk_sys,
   output logic rx_lo,
   output logic rx_up,
   output logic alarm_in
);
   // neighbours idle all three lines low and send raw levels only, never check characters
   // the wiring always matches the topology in use, so no hard reset is requested
   initial
   begin
      rx_lo = 1'b0;
      rx_up = 1'b0;
      alarm_in = 1'b0;
   end
   // drive the selected lines high for n cycles, then back to idle
   task automatic burst(input logic lo, input logic up, input int n);
      @(negedge clk_sys);
      rx_lo = lo;
      rx_up = up;
      repeat (n) @(negedge clk_sys);
      rx_lo = 1'b0;
      rx_up = 1'b0;
   endtask
endmodule

// File: uic_interface_config_test.sv
`timescale 1ns/10ps
module uic_interface_config_test
   import uic_pkg::*;
;
   logic clk_sys, rst, reg_wr_en, reg_wr_from_up, reg_wr_refused, result_transfer;
   logic select_up_host_cmd, select_down_host_cmd, software_power_on_reset, acq_start, acq_end;
   logic lower_receive_port, upper_receive_port, alarm_input_pin, host_path_indicator;
   logic utx_o, utx_oe, ltx_o, ltx_oe, alm_o, alm_oe;
   logic keepalive_count_enable, check_byte_required, crc_disable, alarm_enable, double_buffer_enable;
   logic [1:0] serial_topology_sel;
   logic [7:0] reg_wr_addr, reg_rd_addr;
   logic [15:0] reg_wr_data, reg_rd_data, primary_alarm_status;
   int error_cnt, check_count, cyc;
   uic_interface_config dut_u (.clk_sys(clk_sys), .rst(rst), .reg_wr_en(reg_wr_en),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_from_up(reg_wr_from_up),
      .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_refused(reg_wr_refused),
      .select_up_host_cmd(select_up_host_cmd), .select_down_host_cmd(select_down_host_cmd),
      .software_power_on_reset(software_power_on_reset), .primary_alarm_status(primary_alarm_status),
      .acq_start(acq_start), .acq_end(acq_end), .result_transfer(result_transfer),
      .lower_receive_port(lower_receive_port), .upper_receive_port(upper_receive_port),
      .alarm_input_pin(alarm_input_pin), .upper_transmit_port_o(utx_o), .upper_transmit_port_oe(utx_oe),
      .lower_transmit_port_o(ltx_o), .lower_transmit_port_oe(ltx_oe), .alarm_output_pin_o(alm_o),
      .alarm_output_pin_oe(alm_oe), .serial_topology_sel(serial_topology_sel),
      .host_path_indicator(host_path_indicator), .keepalive_count_enable(keepalive_count_enable),
      .check_byte_required(check_byte_required), .crc_disable(crc_disable),
      .alarm_enable(alarm_enable), .double_buffer_enable(double_buffer_enable));
   uic_neighbour nb_u (.clk_sys(clk_sys), .rx_lo(lower_receive_port), .rx_up(upper_receive_port),
      .alarm_in(alarm_input_pin));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] d, input logic up);
      @(negedge clk_sys);
      reg_wr_en = 1'b1;
      reg_wr_addr = UIC_IFCFG_OFS;
      reg_wr_data = d;
      reg_wr_from_up = up;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      reg_rd_addr = a;
      @(negedge clk_sys);
      chk("read", reg_rd_data, e);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(negedge clk_sys);
      {select_up_host_cmd, select_down_host_cmd, software_power_on_reset, acq_start, acq_end} = m;
      @(negedge clk_sys);
      {select_up_host_cmd, select_down_host_cmd, software_power_on_reset, acq_start, acq_end} = 5'h00;
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      {reg_wr_en, reg_wr_from_up, reg_wr_addr, reg_wr_data, reg_rd_addr} = '0;
      {select_up_host_cmd, select_down_host_cmd, software_power_on_reset, acq_start, acq_end} = 5'h00;
      primary_alarm_status = UIC_ZERO16;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      rd(UIC_IFCFG_OFS, UIC_IFCFG_RST);
      chk("levels", {serial_topology_sel, host_path_indicator, keepalive_count_enable, check_byte_required,
         crc_disable, alarm_enable, double_buffer_enable}, 16'h00E8);
      rd(UIC_FILTCFG_OFS, UIC_ZERO16);
      wr(16'h3EF6, 1'b0);
      chk("refused", reg_wr_refused, 16'h0001);
      rd(UIC_IFCFG_OFS, UIC_IFCFG_RST);
      wr(16'hFEFE, 1'b1);
      chk("accepted", reg_wr_refused, 16'h0000);
      chk("levels", {serial_topology_sel, host_path_indicator, keepalive_count_enable, check_byte_required,
         crc_disable, alarm_enable, double_buffer_enable}, 16'h00FE);
      rd(UIC_IFCFG_OFS, 16'hFFFE);
      pulse(5'h04);
      rd(UIC_IFCFG_OFS, 16'hF10A);
      pulse(5'h08);
      chk("host", host_path_indicator, 16'h0000);
      fork
         nb_u.burst(1'b1, 1'b1, 4);
         begin
            repeat (4) @(negedge clk_sys);
            chk("relay", {utx_oe, utx_o, ltx_oe, ltx_o}, 16'h000F);
         end
      join
      repeat (50) @(negedge clk_sys);
      chk("float", {utx_oe, ltx_oe}, 16'h0000);
      primary_alarm_status = 16'h0010;
      repeat (3) @(negedge clk_sys);
      chk("alarm", {alm_oe, alm_o}, 16'h0003);
      primary_alarm_status = UIC_ZERO16;
      fork
         nb_u.alarm_in = 1'b1;
         repeat (4) @(negedge clk_sys);
      join
      chk("pass", {alm_oe, alm_o}, 16'h0003);
      nb_u.alarm_in = 1'b0;
      wr(16'hF008, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk("alarm off", alm_oe, 16'h0000);
      rd(UIC_IFCFG_OFS, 16'hF008);
      wr(16'hA008, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk("diff idle", {ltx_oe, ltx_o, alm_oe}, 16'h0004);
      pulse(5'h04);
      rd(UIC_IFCFG_OFS, 16'hA008);
      wr(16'hA00A, 1'b1);
      primary_alarm_status = 16'h8000;
      repeat (3) @(negedge clk_sys);
      chk("diff alarm", {ltx_o, alm_oe}, 16'h0002);
      primary_alarm_status = UIC_ZERO16;
      pulse(5'h10);
      wr(16'h4008, 1'b1);
      pulse(5'h08);
      chk("down host", host_path_indicator, 16'h0001);
      // only one acquisition is started per buffered pair
      pulse(5'h01);
      chk("xfer", result_transfer, 16'h0001);
      wr(16'h4009, 1'b1);
      pulse(5'h01);
      chk("hold", result_transfer, 16'h0000);
      pulse(5'h02);
      chk("xfer next", result_transfer, 16'h0001);
      @(negedge clk_sys);
      acq_end = 1'b1;
      @(negedge clk_sys);
      {acq_start, acq_end} = 2'b10;
      @(negedge clk_sys);
      acq_start = 1'b0;
      chk("xfer chained", result_transfer, 16'h0001);
      repeat (2) @(negedge clk_sys);
      complete_run();
   end
endmodule
